// File: core/lcd_cmd_decoder.sv
// Function
// - rmw mode: column steps on writes only
// - soft reset during standby enters sleep
// - scan direction from bit 3, low ignored
// - power control low bits set circuits
// - volume command loads five-bit level
// - display off plus entire on saves
// - standby setting picks sleep or standby
// - upper nibble F other than F0 enters test mode
// - code F0 leaves test mode
// - host writes only defined codes; the port drops only undefined test codes
// - no hard reset during power save
// - host refreshes settings including test exit
// - avoid all-white first display
// - host waits 5 ms during setup
`timescale 1ns/1ns
module lcd_cmd_decoder
  import lcd_cmd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // host bus
  lcd_bus_if.device bus,
  // user side: decoded state
  output logic scan_reverse,
  output logic [2:0] power_mode,
  output logic [4:0] lcd_drive_voltage,
  output logic display_on,
  output logic entire_on,
  output logic standby_sel,
  output lcd_cmd_pkg::pwr_state_t pwr_state,
  output logic test_mode,
  output logic rmw_mode,
  output logic [7:0] column_addr
);
  // ----------------------------------------------------------------
  // strobe edge detect
  // ----------------------------------------------------------------
  logic wr_n_reg, wr_n_next; // previous write strobe
  logic rd_n_reg, rd_n_next; // previous read strobe
  logic wr_rise;             // end of a host write
  logic rd_rise;             // end of a host read
  logic cmd_wr;              // command write seen
  logic data_wr;             // display data write seen
  logic data_rd;             // display data read seen
  logic hard_rst;            // hardware reset pin low
  logic [7:0] code;          // byte on the bus

  // strobes are idle high, so their edges are compared
  always_comb begin
    wr_n_next = bus.wr_n;
    rd_n_next = bus.rd_n;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
    end else begin
      wr_n_reg <= wr_n_next;
      rd_n_reg <= rd_n_next;
    end
  end

  // code is taken as the write strobe releases, data still valid
  assign code = bus.d_host;
  assign wr_rise = bus.wr_n && !wr_n_reg;
  assign rd_rise = bus.rd_n && !rd_n_reg;
  assign cmd_wr = wr_rise && !bus.register_select;
  assign data_wr = wr_rise && bus.register_select;
  assign data_rd = rd_rise && bus.register_select;
  assign hard_rst = !bus.hard_reset_input_n;
  // no read-back path in this block; bus stays released
  assign bus.d_dev = 8'h00;
  assign bus.d_dev_oe = 1'b0;

  // ----------------------------------------------------------------
  // command state
  // ----------------------------------------------------------------
  logic scan_reg, scan_next;           // com scan direction
  logic [2:0] power_reg, power_next;   // power circuit blocks
  logic [4:0] volume_reg, volume_next; // electronic control
  logic disp_reg, disp_next;           // display on
  logic entire_reg, entire_next;       // entire display on
  logic stby_reg, stby_next;           // standby setting
  pwr_state_t pwr_reg, pwr_next;       // power save state
  logic test_reg, test_next;           // internal test mode
  logic rmw_reg, rmw_next;             // read-modify-write
  logic [7:0] col_reg, col_next;       // column counter

  // decoder: one command per write strobe
  always_comb begin
    scan_next = scan_reg;
    power_next = power_reg;
    volume_next = volume_reg;
    disp_next = disp_reg;
    entire_next = entire_reg;
    stby_next = stby_reg;
    pwr_next = pwr_reg;
    test_next = test_reg;
    rmw_next = rmw_reg;
    col_next = col_reg;
    if (hard_rst) begin
      // pin reset clears as the software reset plus display, entire on and standby, and goes to normal
      scan_next = 1'b0;
      power_next = POWER_RST;
      volume_next = VOLUME_RST;
      disp_next = 1'b0;
      entire_next = 1'b0;
      stby_next = 1'b0;
      pwr_next = PWR_NORMAL;
      test_next = 1'b0;
      rmw_next = 1'b0;
      col_next = COLUMN_RST;
    end else if (cmd_wr && test_reg && code != CMD_SOFT_RESET) begin
      // in test mode only the exit code and soft reset are honoured
      if (code == CMD_TEST_EXIT) begin
        test_next = 1'b0;
      end
    end else if (cmd_wr) begin
      if (code == CMD_RMW) begin
        rmw_next = 1'b1;
      end else if (code == CMD_RMW_END) begin
        rmw_next = 1'b0;
      end else if (code == CMD_SOFT_RESET) begin
        scan_next = 1'b0;
        power_next = POWER_RST;
        volume_next = VOLUME_RST;
        rmw_next = 1'b0;
        col_next = COLUMN_RST;
        test_next = 1'b0;
        // standby turns into sleep on reset
        if (pwr_reg == PWR_STANDBY) begin
          pwr_next = PWR_SLEEP;
        end
      end else if (code == CMD_TEST_EXIT) begin
        // exit code outside test mode is a harmless refresh
        test_next = 1'b0;
      end else if (code[7:4] == OP_TEST_HI) begin
        test_next = 1'b1;
      end else if (code[7:4] == OP_SCAN_HI) begin
        scan_next = code[SCAN_BIT];
      end else if (code[7:3] == OP_POWER_HI) begin
        power_next = code[2:0];
      end else if (code[7:5] == OP_VOLUME_HI) begin
        volume_next = code[4:0];
      end else if (code == CMD_DISP_OFF) begin
        disp_next = 1'b0;
      end else if (code == CMD_DISP_ON) begin
        disp_next = 1'b1;
        pwr_next = PWR_NORMAL;
      end else if (code == CMD_ENTIRE_OFF) begin
        entire_next = 1'b0;
        pwr_next = PWR_NORMAL;
      end else if (code == CMD_ENTIRE_ON) begin
        entire_next = 1'b1;
        // display already off: power save, kind picked by standby
        if (!disp_reg) begin
          pwr_next = stby_reg ? PWR_STANDBY : PWR_SLEEP;
        end
      end else if (code == CMD_STANDBY_OFF) begin
        stby_next = 1'b0;
      end else if (code == CMD_STANDBY_ON) begin
        stby_next = 1'b1;
      end
    end else if (data_wr && !test_reg) begin
      col_next = col_reg + 8'h01;
    end else if (data_rd && !test_reg && !rmw_reg) begin
      // in rmw the read leaves the column for the write back
      col_next = col_reg + 8'h01;
    end
  end

  // register the command state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scan_reg <= 1'b0;
      power_reg <= POWER_RST;
      volume_reg <= VOLUME_RST;
      disp_reg <= 1'b0;
      entire_reg <= 1'b0;
      stby_reg <= 1'b0;
      pwr_reg <= PWR_NORMAL;
      test_reg <= 1'b0;
      rmw_reg <= 1'b0;
      col_reg <= COLUMN_RST;
    end else begin
      scan_reg <= scan_next;
      power_reg <= power_next;
      volume_reg <= volume_next;
      disp_reg <= disp_next;
      entire_reg <= entire_next;
      stby_reg <= stby_next;
      pwr_reg <= pwr_next;
      test_reg <= test_next;
      rmw_reg <= rmw_next;
      col_reg <= col_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from flops
  // ----------------------------------------------------------------
  assign scan_reverse = scan_reg;
  assign power_mode = power_reg;
  assign lcd_drive_voltage = volume_reg;
  assign display_on = disp_reg;
  assign entire_on = entire_reg;
  assign standby_sel = stby_reg;
  assign pwr_state = pwr_reg;
  assign test_mode = test_reg;
  assign rmw_mode = rmw_reg;
  assign column_addr = col_reg;
endmodule

// File: core/lcd_cmd_pkg.sv
package lcd_cmd_pkg;
  // ----------------------------------------------------------------
  // command codes, written with register_select low
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RMW = 8'hE0;
  localparam logic [7:0] CMD_RMW_END = 8'hEE;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hE2;
  localparam logic [7:0] CMD_TEST_EXIT = 8'hF0;
  localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
  localparam logic [7:0] CMD_DISP_ON = 8'hAF;
  localparam logic [7:0] CMD_ENTIRE_OFF = 8'hA4;
  localparam logic [7:0] CMD_ENTIRE_ON = 8'hA5;
  localparam logic [7:0] CMD_STANDBY_OFF = 8'hA8;
  localparam logic [7:0] CMD_STANDBY_ON = 8'hA9;
  // ----------------------------------------------------------------
  // opcode field masks and values
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_SCAN_HI = 4'hC;
  localparam logic [3:0] OP_TEST_HI = 4'hF;
  localparam logic [4:0] OP_POWER_HI = 5'h05;
  localparam logic [2:0] OP_VOLUME_HI = 3'h4;
  localparam int SCAN_BIT = 3;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] POWER_RST = 3'h0;
  localparam logic [4:0] VOLUME_RST = 5'h00;
  localparam logic [7:0] COLUMN_RST = 8'h00;
  // ----------------------------------------------------------------
  // host timing: setup wait, 5 ms at 250 MHz
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SETUP_WAIT_MS = 5;
  localparam int SETUP_WAIT_CYC = SETUP_WAIT_MS * 1000 * CLK_MHZ;
  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWR_NORMAL = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_SLEEP = 2'b10
  } pwr_state_t;
endpackage

// File: core/lcd_bus_if.sv
`timescale 1ns/1ns
interface lcd_bus_if;
  logic register_select; // high selects display data
  logic rd_n;            // read strobe, active low
  logic wr_n;            // write strobe, active low
  logic [7:0] d_host;    // data driven by host
  logic d_host_oe;       // host drives data bus
  logic [7:0] d_dev;     // data driven by device
  logic d_dev_oe;        // device drives data bus
  logic hard_reset_input_n; // hardware reset, active low
  modport device (
    input register_select, rd_n, wr_n, d_host, d_host_oe,
    input hard_reset_input_n,
    output d_dev, d_dev_oe
  );
  modport host (
    output register_select, rd_n, wr_n, d_host, d_host_oe,
    output hard_reset_input_n,
    input d_dev, d_dev_oe
  );
endinterface

// File: core/lcd_host_port.sv
`timescale 1ns/1ns
module lcd_host_port
  import lcd_cmd_pkg::*;
#(
  // setup wait in cycles, shorten in simulation
  parameter int WAIT_CYC = SETUP_WAIT_CYC
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // bus to device
  lcd_bus_if.host bus,
  // user request
  input wire logic req_valid,
  input wire logic req_data,
  input wire logic [7:0] req_byte,
  output logic req_ready,
  // user controls
  input wire logic hard_reset_req,
  input wire logic setup_wait_req,
  output logic in_power_save
);
  // ----------------------------------------------------------------
  // write sequencer: strobe low one cycle, high one cycle
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_STROBE = 2'b01,
    H_HOLD = 2'b10,
    H_WAIT = 2'b11
  } hstate_t;
  hstate_t st_reg, st_next;        // sequencer state
  logic [7:0] dat_reg, dat_next;   // byte on the bus
  logic rs_reg, rs_next;           // register select
  logic [31:0] cnt_reg, cnt_next;  // setup wait counter
  logic ps_reg, ps_next;           // power save entered
  logic prev_off_reg, prev_off_next; // display is switched off
  logic legal;                     // request may be written

  // undefined test codes are never sent, except the exit code
  assign legal = req_data || req_byte == CMD_TEST_EXIT ||
                 req_byte[7:4] != OP_TEST_HI;

  // sequencer next state
  always_comb begin
    st_next = st_reg;
    dat_next = dat_reg;
    rs_next = rs_reg;
    cnt_next = cnt_reg;
    ps_next = ps_reg;
    prev_off_next = prev_off_reg;
    unique case (st_reg)
      H_IDLE: begin
        if (setup_wait_req) begin
          cnt_next = 32'(WAIT_CYC);
          st_next = H_WAIT;
        end else if (req_valid && !legal) begin
          st_next = H_IDLE; // dropped silently
        end else if (req_valid) begin
          dat_next = req_byte;
          rs_next = req_data;
          st_next = H_STROBE;
          if (!req_data) begin
            // display off then entire on means power save
            if (prev_off_reg && req_byte == CMD_ENTIRE_ON) begin
              ps_next = 1'b1;
            end else if (req_byte == CMD_DISP_ON ||
                         req_byte == CMD_ENTIRE_OFF) begin
              ps_next = 1'b0;
            end
            // track the display switch as the decoder sees it
            if (req_byte == CMD_DISP_OFF) begin
              prev_off_next = 1'b1;
            end else if (req_byte == CMD_DISP_ON) begin
              prev_off_next = 1'b0;
            end
          end
        end
      end
      H_STROBE: st_next = H_HOLD;
      H_HOLD: st_next = H_IDLE;
      H_WAIT: begin
        if (cnt_reg <= 32'h1) begin
          st_next = H_IDLE;
        end else begin
          cnt_next = cnt_reg - 32'h1;
        end
      end
    endcase
    // a pin reset turns the display off in the decoder
    if (hard_reset_req && !ps_reg) begin
      prev_off_next = 1'b1;
    end
  end

  // register the sequencer
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= H_IDLE;
      dat_reg <= 8'h00;
      rs_reg <= 1'b0;
      cnt_reg <= 32'h0;
      ps_reg <= 1'b0;
      prev_off_reg <= 1'b1; // decoder starts with display off
    end else begin
      st_reg <= st_next;
      dat_reg <= dat_next;
      rs_reg <= rs_next;
      cnt_reg <= cnt_next;
      ps_reg <= ps_next;
      prev_off_reg <= prev_off_next;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  assign req_ready = st_reg == H_IDLE && !setup_wait_req;
  assign bus.register_select = rs_reg;
  assign bus.rd_n = 1'b1;
  assign bus.wr_n = st_reg != H_STROBE;
  assign bus.d_host = dat_reg;
  assign bus.d_host_oe = st_reg == H_STROBE || st_reg == H_HOLD;
  // reset pin blocked while in power save
  assign bus.hard_reset_input_n = !(hard_reset_req && !ps_reg);
  assign in_power_save = ps_reg;
endmodule

// File: dv/lcd_cmd_decoder_assertions.sv
`timescale 1ns/1ns
module lcd_cmd_decoder_assertions
  import lcd_cmd_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // host bus wires
  input wire logic register_select,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] d_host,
  input wire logic d_host_oe,
  input wire logic hard_reset_input_n,
  // decoded state
  input wire logic scan_reverse,
  input wire logic [2:0] power_mode,
  input wire logic [4:0] lcd_drive_voltage,
  input wire logic display_on,
  input wire logic standby_sel,
  input wire lcd_cmd_pkg::pwr_state_t pwr_state,
  input wire logic test_mode,
  input wire logic rmw_mode,
  input wire logic [7:0] column_addr
);
  import lcd_cmd_pkg::*;
  // ------------------------------------------------------------
  // one clock domain
  // ------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // strobe released: byte was on the bus the cycle before
  sequence wr_cmd_s;
    $rose(wr_n) && !register_select && hard_reset_input_n && !test_mode;
  endsequence
  sequence wr_data_s;
    $rose(wr_n) && register_select && hard_reset_input_n;
  endsequence
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  strobe_shape_a: assert property (
    $fell(wr_n) |-> rd_n && d_host_oe ##1 wr_n && d_host_oe)
    else $error("write strobe not one cycle with data driven");
  scan_dir_a: assert property (
    wr_cmd_s ##0 ($past(d_host[7:4]) == OP_SCAN_HI)
    |=> scan_reverse == $past(d_host[SCAN_BIT], 2))
    else $error("scan direction not taken from bit 3");
  power_mode_a: assert property (
    wr_cmd_s ##0 ($past(d_host[7:3]) == OP_POWER_HI)
    |=> power_mode == $past(d_host[2:0], 2))
    else $error("power mode not loaded");
  volume_load_a: assert property (
    wr_cmd_s ##0 ($past(d_host[7:5]) == OP_VOLUME_HI)
    |=> lcd_drive_voltage == $past(d_host[4:0], 2))
    else $error("drive voltage level not loaded");
  rmw_step_a: assert property (
    rmw_mode && !test_mode ##0 wr_data_s
    |=> column_addr == 8'($past(column_addr) + 8'h01))
    else $error("column did not step on write");
  soft_sleep_a: assert property (
    wr_cmd_s ##0 ($past(d_host) == CMD_SOFT_RESET && pwr_state == PWR_STANDBY)
    |=> pwr_state == PWR_SLEEP)
    else $error("soft reset in standby did not sleep");
  save_enter_a: assert property (
    wr_cmd_s ##0 ($past(d_host) == CMD_ENTIRE_ON && !display_on)
    |=> pwr_state == (standby_sel ? PWR_STANDBY : PWR_SLEEP))
    else $error("power save state wrong");
  hard_clear_a: assert property (
    !hard_reset_input_n |=> !test_mode && !rmw_mode && !scan_reverse
    && power_mode == 3'h0 && lcd_drive_voltage == 5'h00
    && column_addr == 8'h00)
    else $error("hard reset left state behind");
  save_no_reset_a: assert property (
    pwr_state != PWR_NORMAL |-> hard_reset_input_n)
    else $error("hard reset pulsed during power save");
  host_no_test_a: assert property (
    !wr_n && !register_select |-> !(d_host[7:4] == OP_TEST_HI
    && d_host[3:0] != 4'h0))
    else $error("host wrote a test code");
endmodule

// File: dv/lcd_driver_command_decoder_tb.sv
`timescale 1ns/1ns
module lcd_driver_command_decoder_tb;
  import lcd_cmd_pkg::*;
  // short setup wait keeps the run brief
  localparam int WAIT_SIM = 10;
  logic sys_clk, rstn, req_valid, req_data, req_ready;
  logic hard_reset_req, setup_wait_req, in_power_save;
  logic [7:0] req_byte, column_addr, column_b;
  logic scan_reverse, display_on, entire_on, standby_sel;
  logic test_mode, rmw_mode, test_b;
  logic [2:0] power_mode;
  logic [4:0] lcd_drive_voltage, volume_b;
  pwr_state_t pwr_state;
  int fails, comparisons, cycles, n;
  // ------------------------------------------------------------
  // pair under test, plus a lone decoder on a raw bus
  // ------------------------------------------------------------
  lcd_bus_if bus_a();
  lcd_bus_if bus_b();
  lcd_host_port #(.WAIT_CYC(WAIT_SIM)) lcd_host_port_inst (
    .sys_clk(sys_clk), .rstn(rstn), .bus(bus_a),
    .req_valid(req_valid), .req_data(req_data), .req_byte(req_byte),
    .req_ready(req_ready), .hard_reset_req(hard_reset_req),
    .setup_wait_req(setup_wait_req), .in_power_save(in_power_save));
  lcd_cmd_decoder lcd_cmd_decoder_inst (
    .sys_clk(sys_clk), .rstn(rstn), .bus(bus_a),
    .scan_reverse(scan_reverse), .power_mode(power_mode),
    .lcd_drive_voltage(lcd_drive_voltage), .display_on(display_on),
    .entire_on(entire_on), .standby_sel(standby_sel),
    .pwr_state(pwr_state), .test_mode(test_mode), .rmw_mode(rmw_mode),
    .column_addr(column_addr));
  // second decoder lets the bench break host rules on purpose
  lcd_cmd_decoder lcd_cmd_decoder_b_inst (
    .sys_clk(sys_clk), .rstn(rstn), .bus(bus_b),
    .scan_reverse(), .power_mode(), .lcd_drive_voltage(volume_b),
    .display_on(), .entire_on(), .standby_sel(), .pwr_state(),
    .test_mode(test_b), .rmw_mode(), .column_addr(column_b));
  lcd_cmd_decoder_assertions lcd_cmd_decoder_assertions_inst (
    .sys_clk(sys_clk), .rstn(rstn),
    .register_select(bus_a.register_select), .rd_n(bus_a.rd_n),
    .wr_n(bus_a.wr_n), .d_host(bus_a.d_host),
    .d_host_oe(bus_a.d_host_oe),
    .hard_reset_input_n(bus_a.hard_reset_input_n),
    .scan_reverse(scan_reverse), .power_mode(power_mode),
    .lcd_drive_voltage(lcd_drive_voltage), .display_on(display_on),
    .standby_sel(standby_sel), .pwr_state(pwr_state),
    .test_mode(test_mode), .rmw_mode(rmw_mode),
    .column_addr(column_addr));
  // ------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // whole run needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      stop_test();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // one request through the host port, then let the decoder settle
  task automatic send(input logic dat, input logic [7:0] b);
    int k;
    k = 0;
    @(posedge sys_clk);
    req_valid <= 1'b1;
    req_data <= dat;
    req_byte <= b;
    @(posedge sys_clk);
    while (req_ready !== 1'b1 && k < 100) begin
      k++;
      @(posedge sys_clk);
    end
    req_valid <= 1'b0;
    check("ready", 8'h01, 8'(k < 100));
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  // raw access on the spare bus; released data shows the inverse
  task automatic raw(input logic rs, input logic [7:0] b, input logic rd);
    @(posedge sys_clk);
    bus_b.register_select <= rs;
    bus_b.d_host <= b;
    bus_b.d_host_oe <= !rd;
    if (rd) bus_b.rd_n <= 1'b0;
    else bus_b.wr_n <= 1'b0;
    @(posedge sys_clk);
    bus_b.rd_n <= 1'b1;
    bus_b.wr_n <= 1'b1;
    @(posedge sys_clk);
    bus_b.d_host_oe <= 1'b0;
    bus_b.d_host <= ~b;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse_hard();
    @(posedge sys_clk);
    hard_reset_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    hard_reset_req <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_data = 1'b0;
    req_byte = 8'h00;
    hard_reset_req = 1'b0;
    setup_wait_req = 1'b0;
    bus_b.register_select = 1'b0;
    bus_b.rd_n = 1'b1;
    bus_b.wr_n = 1'b1;
    bus_b.d_host = 8'h00;
    bus_b.d_host_oe = 1'b0;
    bus_b.hard_reset_input_n = 1'b1;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    send(1'b0, 8'hC8);
    check("scan", 8'h01, 8'(scan_reverse));
    send(1'b0, 8'hC7);
    check("scan", 8'h00, 8'(scan_reverse));
    for (int v = 0; v < 8; v++) begin
      send(1'b0, 8'h28 | 8'(v));
      check("power", 8'(v), 8'(power_mode));
    end
    send(1'b0, 8'h9F);
    check("volume", 8'h1F, 8'(lcd_drive_voltage));
    $display("test field commands done");
    send(1'b0, CMD_RMW);
    check("rmw", 8'h01, 8'(rmw_mode));
    repeat (3) send(1'b1, 8'h55);
    check("column", 8'h03, column_addr);
    send(1'b0, CMD_RMW_END);
    check("rmw", 8'h00, 8'(rmw_mode));
    $display("test rmw done");
    send(1'b0, CMD_STANDBY_ON);
    check("standby", 8'h01, 8'(standby_sel));
    send(1'b0, CMD_DISP_OFF);
    send(1'b0, CMD_ENTIRE_ON);
    check("pwr", 8'(PWR_STANDBY), 8'(pwr_state));
    check("entire", 8'h01, 8'(entire_on));
    send(1'b0, CMD_SOFT_RESET);
    check("pwr", 8'(PWR_SLEEP), 8'(pwr_state));
    send(1'b0, CMD_DISP_ON);
    check("disp", 8'h01, 8'(display_on));
    check("pwr", 8'(PWR_NORMAL), 8'(pwr_state));
    send(1'b0, 8'h2B);
    send(1'b0, CMD_STANDBY_OFF);
    send(1'b0, CMD_DISP_OFF);
    send(1'b0, CMD_ENTIRE_ON);
    check("pwr", 8'(PWR_SLEEP), 8'(pwr_state));
    check("save", 8'h01, 8'(in_power_save));
    pulse_hard();
    check("power", 8'h03, 8'(power_mode));
    send(1'b0, CMD_DISP_ON);
    pulse_hard();
    check("power", 8'h00, 8'(power_mode));
    send(1'b0, 8'hF5);
    check("test", 8'h00, 8'(test_mode));
    send(1'b0, CMD_TEST_EXIT);
    check("test", 8'h00, 8'(test_mode));
    $display("test power save done");
    @(posedge sys_clk);
    setup_wait_req <= 1'b1;
    @(posedge sys_clk);
    setup_wait_req <= 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    check("wait", 8'h01, 8'(n >= WAIT_SIM && n <= WAIT_SIM + 3));
    raw(1'b0, 8'hF5, 1'b0);
    check("test", 8'h01, 8'(test_b));
    raw(1'b0, 8'h8A, 1'b0);
    check("volume", 8'h00, 8'(volume_b));
    raw(1'b0, CMD_TEST_EXIT, 1'b0);
    check("test", 8'h00, 8'(test_b));
    raw(1'b0, 8'h8A, 1'b0);
    check("volume", 8'h0A, 8'(volume_b));
    raw(1'b0, CMD_TEST_EXIT, 1'b0);
    check("test", 8'h00, 8'(test_b));
    raw(1'b0, 8'hFC, 1'b0);
    check("test", 8'h01, 8'(test_b));
    raw(1'b0, CMD_SOFT_RESET, 1'b0);
    check("test", 8'h00, 8'(test_b));
    check("volume", 8'h00, 8'(volume_b));
    raw(1'b0, 8'h8A, 1'b0);
    check("volume", 8'h0A, 8'(volume_b));
    raw(1'b0, 8'hFC, 1'b0);
    @(posedge sys_clk);
    bus_b.hard_reset_input_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    bus_b.hard_reset_input_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check("test", 8'h00, 8'(test_b));
    check("volume", 8'h00, 8'(volume_b));
    raw(1'b0, CMD_RMW, 1'b0);
    raw(1'b1, 8'h00, 1'b1);
    check("column", 8'h00, column_b);
    raw(1'b1, 8'h33, 1'b0);
    check("column", 8'h01, column_b);
    raw(1'b0, CMD_RMW_END, 1'b0);
    raw(1'b1, 8'h00, 1'b1);
    check("column", 8'h02, column_b);
    $display("test raw bus done");
    stop_test();
  end
endmodule
